// *** hw/dwlc_core.v ***
// digital i/o core: coils, inputs, latches, counters and host alive timer
// Notes on behaviour
// - timeout setting 0..255 in tenths of a second, host readable and writable
// - enable coil set by 0xFF00, cleared by 0x0000, reads back its state
// - timeout flag readable; writing 0xFF00 or 1 clears it
// - read of module alive location refreshes timer and answers normally
// - read of broadcast location refreshes timer and sends no answer
// - 32 safe output bits, host readable and writable
// - 32 power-on output bits, readable, writable; reset returns them to 0 before outputs load them after power-up
// - 32 output channel bits, writable and readable back
// - 32 read-only input bits show current input levels
// - per input, latch set by a high level, held until cleared
// - per input, latch set by a low level, held until cleared
// - writing 1 or 0xFF00 to latch clear coil clears all latches whose level is absent
// - normal mode counters saturate at 65535
// - overflow mode counters wrap to 0 and set overflow bit
// - mode coil: 0xFF00 overflow, 0x0000 normal; normal after reset
// - single coil write 0xFF00 clears that channel's counter; write-only
// - multiple coil write clears counters whose bit is 1
// - read-only 16-bit count per channel without overflow
// - 32-bit view: count, overflow bit 16, rest zero, no side effect
// - second view clears overflow after read, keeps count
// - third view clears count and overflow after read
// - refusal due to expired timer answers exception 0x04
// - element address is reference number minus one per space
`timescale 1ns/1ns
`default_nettype none
`include "dwlc_defs.vh"

module dwlc_core #(
  parameter [31:0] TENTH_CYCLES = `DWLC_TMO_UNIT_CYC
) (
  // clock and reset
  input  wire        CLK_SYS,
  input  wire        RSTN,
  // decoded request, one element per request
  input  wire        REQ_VALID,
  input  wire [7:0]  REQ_FUNC,
  input  wire [15:0] REQ_ADDR,
  input  wire [15:0] REQ_DATA,
  // answer
  output reg         RSP_VALID,
  output reg  [15:0] RSP_DATA,
  output reg  [7:0]  RSP_EXC,
  // pins
  input  wire [31:0] DIN,
  output reg  [31:0] DOUT,
  output reg         HOST_TMO
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [31:0] din_s;
  reg  [31:0] din_q;
  reg  [31:0] out_reg;
  reg  [31:0] safe_reg;
  reg  [31:0] pwr_reg;
  reg  [31:0] latch_hi;
  reg  [31:0] latch_lo;
  reg  [15:0] cnt [0:31];
  reg  [31:0] ovf;
  reg         cnt_mode;
  reg         wdt_en;
  reg         wdt_exp;
  reg  [7:0]  tmo_set;
  reg  [31:0] tick_cnt;
  reg  [7:0]  unit_cnt;
  reg         init_done;
  reg  [15:0] snap_hi;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  reg         next_rsp_valid;
  reg  [15:0] next_rsp_data;
  reg  [7:0]  next_rsp_exc;
  reg         wr_out;
  reg         wr_safe;
  reg         wr_pwr;
  reg         wr_en;
  reg         wr_mode;
  reg         wr_tmo;
  reg         clr_exp;
  reg         clr_latch;
  reg         kick;
  reg         snap_ld;
  reg  [31:0] clr_cnt;
  reg  [31:0] rd_ovc;
  reg  [31:0] rd_allc;
  reg         bitv;
  reg  [15:0] off;
  reg  [4:0]  ch;

  wire [4:0]  bi        = REQ_ADDR[4:0];
  wire        is_rd_bit = (REQ_FUNC == `DWLC_FC_RD_COIL) || (REQ_FUNC == `DWLC_FC_RD_DISC);
  wire        is_rd_wrd = (REQ_FUNC == `DWLC_FC_RD_HOLD) || (REQ_FUNC == `DWLC_FC_RD_INREG);
  wire        is_wr_bit = (REQ_FUNC == `DWLC_FC_WR_COIL) || (REQ_FUNC == `DWLC_FC_WR_COILS);
  wire        is_wr_wrd = (REQ_FUNC == `DWLC_FC_WR_HOLD) || (REQ_FUNC == `DWLC_FC_WR_HOLDS);
  // single coil writes take the coil codes, multi coil writes take bit 0
  wire        val_on    = (REQ_FUNC == `DWLC_FC_WR_COIL) ? (REQ_DATA == `DWLC_COIL_ON) : REQ_DATA[0];
  // flag and latch clear coils also take a plain 1 on a single coil write
  wire        val_ok    = (REQ_FUNC != `DWLC_FC_WR_COIL) || (REQ_DATA == `DWLC_COIL_ON) ||
                          (REQ_DATA == `DWLC_COIL_OFF) ||
                          ((REQ_DATA == `DWLC_COIL_ONE) &&
                           ((REQ_ADDR == `DWLC_A_WDT_FLAG) || (REQ_ADDR == `DWLC_A_LATCH_CLR)));
  wire        val_one   = (REQ_FUNC == `DWLC_FC_WR_COIL) ?
                          ((REQ_DATA == `DWLC_COIL_ON) || (REQ_DATA == `DWLC_COIL_ONE)) : REQ_DATA[0];
  wire        in_bank   = REQ_ADDR < `DWLC_BANK_LEN;

  always @* begin
    next_rsp_valid = REQ_VALID;
    next_rsp_data  = 16'h0000;
    next_rsp_exc   = `DWLC_EXC_NONE;
    wr_out    = 1'b0;
    wr_safe   = 1'b0;
    wr_pwr    = 1'b0;
    wr_en     = 1'b0;
    wr_mode   = 1'b0;
    wr_tmo    = 1'b0;
    clr_exp   = 1'b0;
    clr_latch = 1'b0;
    kick      = 1'b0;
    snap_ld   = 1'b0;
    clr_cnt   = 32'h0000_0000;
    rd_ovc    = 32'h0000_0000;
    rd_allc   = 32'h0000_0000;
    bitv      = 1'b0;
    off       = 16'h0000;
    ch        = 5'd0;
    if (is_rd_bit) begin
      if (REQ_ADDR < `DWLC_A_IN)
        bitv = out_reg[bi];
      else if (REQ_ADDR < `DWLC_A_LATCH_HI)
        bitv = din_s[bi];
      else if (REQ_ADDR < `DWLC_A_LATCH_LO)
        bitv = latch_hi[bi];
      else if (REQ_ADDR < `DWLC_A_SAFE)
        bitv = latch_lo[bi];
      else if (REQ_ADDR < `DWLC_A_PWR)
        bitv = safe_reg[bi];
      else if (REQ_ADDR < `DWLC_A_PWR + `DWLC_BANK_LEN)
        bitv = pwr_reg[bi];
      else if (REQ_ADDR == `DWLC_A_WDT_EN)
        bitv = wdt_en;
      else if (REQ_ADDR == `DWLC_A_WDT_FLAG)
        bitv = wdt_exp;
      else if (REQ_ADDR == `DWLC_A_CNT_MODE)
        bitv = cnt_mode;
      else
        next_rsp_exc = `DWLC_EXC_ADDR; // write-only and unmapped bits
      next_rsp_data = {15'h0000, bitv};
    end else if (is_wr_bit) begin
      next_rsp_data = REQ_DATA;
      if (!val_ok)
        next_rsp_exc = `DWLC_EXC_VALUE;
      else if (REQ_ADDR < `DWLC_A_IN) begin
        // outputs are frozen at safe values until the flag is cleared
        if (wdt_exp)
          next_rsp_exc = `DWLC_EXC_HOST_TMO;
        else
          wr_out = REQ_VALID;
      end else if (REQ_ADDR >= `DWLC_A_SAFE && REQ_ADDR < `DWLC_A_PWR)
        wr_safe = REQ_VALID;
      else if (REQ_ADDR >= `DWLC_A_PWR && REQ_ADDR < `DWLC_A_PWR + `DWLC_BANK_LEN)
        wr_pwr = REQ_VALID;
      else if (REQ_ADDR == `DWLC_A_WDT_EN)
        wr_en = REQ_VALID;
      else if (REQ_ADDR == `DWLC_A_WDT_FLAG)
        clr_exp = REQ_VALID & val_one;
      else if (REQ_ADDR == `DWLC_A_LATCH_CLR)
        clr_latch = REQ_VALID & val_one;
      else if (REQ_ADDR == `DWLC_A_CNT_MODE)
        wr_mode = REQ_VALID;
      else if (REQ_ADDR >= `DWLC_A_CNT_CLR && REQ_ADDR < `DWLC_A_CNT_MODE)
        clr_cnt[bi] = REQ_VALID & val_on;
      else
        next_rsp_exc = `DWLC_EXC_ADDR;
    end else if (is_rd_wrd) begin
      if (REQ_ADDR == `DWLC_A_BCAST) begin
        kick           = REQ_VALID;
        next_rsp_valid = 1'b0;
      end else if (REQ_FUNC == `DWLC_FC_RD_HOLD) begin
        if (REQ_ADDR == `DWLC_A_TMO)
          next_rsp_data = {8'h00, tmo_set};
        else if (REQ_ADDR == `DWLC_A_KICK)
          kick = REQ_VALID;
        else
          next_rsp_exc = `DWLC_EXC_ADDR;
      end else begin
        if (REQ_ADDR < `DWLC_A_CNT_VIEW)
          next_rsp_data = cnt[bi];
        else if (REQ_ADDR < `DWLC_A_CNT_VIEW + `DWLC_VIEW_LEN)
          off = REQ_ADDR - `DWLC_A_CNT_VIEW;
        else if (REQ_ADDR >= `DWLC_A_CNT_OVC && REQ_ADDR < `DWLC_A_CNT_OVC + `DWLC_VIEW_LEN)
          off = REQ_ADDR - `DWLC_A_CNT_OVC;
        else if (REQ_ADDR >= `DWLC_A_CNT_ALLC && REQ_ADDR < `DWLC_A_CNT_ALLC + `DWLC_VIEW_LEN)
          off = REQ_ADDR - `DWLC_A_CNT_ALLC;
        else
          next_rsp_exc = `DWLC_EXC_ADDR;
        ch = off[5:1];
        if (REQ_ADDR >= `DWLC_A_CNT_VIEW && next_rsp_exc == `DWLC_EXC_NONE) begin
          // low word takes a snapshot so the high word matches it after a clear
          if (!off[0]) begin
            next_rsp_data = cnt[ch];
            snap_ld       = REQ_VALID;
            if (REQ_ADDR >= `DWLC_A_CNT_ALLC)
              rd_allc[ch] = REQ_VALID;
            else if (REQ_ADDR >= `DWLC_A_CNT_OVC)
              rd_ovc[ch] = REQ_VALID;
          end else
            next_rsp_data = snap_hi;
        end
      end
    end else if (is_wr_wrd) begin
      next_rsp_data = REQ_DATA;
      if (REQ_ADDR == `DWLC_A_TMO) begin
        if (REQ_DATA[15:8] != 8'h00)
          next_rsp_exc = `DWLC_EXC_VALUE;
        else
          wr_tmo = REQ_VALID;
      end else
        next_rsp_exc = `DWLC_EXC_ADDR;
    end else
      next_rsp_exc = `DWLC_EXC_FUNC;
  end

  // ----------------------------------------
  // answer, pins, settings
  // ----------------------------------------
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      RSP_VALID <= 1'b0;
      RSP_DATA  <= 16'h0000;
      RSP_EXC   <= `DWLC_EXC_NONE;
      DOUT      <= 32'h0000_0000;
      HOST_TMO  <= 1'b0;
      din_s     <= 32'h0000_0000;
      din_q     <= 32'h0000_0000;
      out_reg   <= 32'h0000_0000;
      safe_reg  <= `DWLC_RST_SAFE;
      pwr_reg   <= `DWLC_RST_PWR;
      cnt_mode  <= 1'b0;
      wdt_en    <= 1'b0;
      tmo_set   <= `DWLC_RST_TMO;
      init_done <= 1'b0;
      snap_hi   <= 16'h0000;
    end else begin
      RSP_VALID <= next_rsp_valid;
      RSP_DATA  <= next_rsp_data;
      RSP_EXC   <= next_rsp_exc;
      din_s     <= DIN;
      din_q     <= din_s;
      init_done <= 1'b1;
      if (!init_done)
        out_reg <= pwr_reg;
      else if (wr_out)
        out_reg[bi] <= val_on;
      if (wr_safe)
        safe_reg[bi] <= val_on;
      if (wr_pwr)
        pwr_reg[bi] <= val_on;
      if (wr_en)
        wdt_en <= val_on;
      if (wr_mode)
        cnt_mode <= val_on;
      if (wr_tmo)
        tmo_set <= REQ_DATA[7:0];
      if (snap_ld)
        snap_hi <= {15'h0000, ovf[ch]};
      DOUT     <= wdt_exp ? safe_reg : out_reg;
      HOST_TMO <= wdt_exp;
    end
  end

  // ----------------------------------------
  // host alive timer
  // ----------------------------------------
  // a setting of zero never expires; a zero-length timeout would lock the host out
  wire tick = (tick_cnt == TENTH_CYCLES - 32'd1);

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      tick_cnt <= 32'h0000_0000;
      unit_cnt <= 8'h00;
      wdt_exp  <= 1'b0;
    end else begin
      if (!wdt_en || kick || wdt_exp) begin
        tick_cnt <= 32'h0000_0000;
        unit_cnt <= 8'h00;
      end else if (tick) begin
        tick_cnt <= 32'h0000_0000;
        unit_cnt <= unit_cnt + 8'h01;
      end else
        tick_cnt <= tick_cnt + 32'h0000_0001;
      // expiry wins over a clear in the same cycle
      if (wdt_en && !kick && !wdt_exp && tick && tmo_set != 8'h00 &&
          unit_cnt + 8'h01 == tmo_set)
        wdt_exp <= 1'b1;
      else if (clr_exp)
        wdt_exp <= 1'b0;
    end
  end

  // ----------------------------------------
  // per input latches and counters
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_ch
      wire ev   = din_s[i] & ~din_q[i];
      wire zero = clr_cnt[i] | rd_allc[i];
      wire wrap = ev & cnt_mode & (cnt[i] == `DWLC_CNT_MAX);
      always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
          latch_hi[i] <= 1'b0;
          latch_lo[i] <= 1'b0;
          cnt[i]      <= 16'h0000;
          ovf[i]      <= 1'b0;
        end else begin
          // a level present during the clear re-arms its latch at once
          latch_hi[i] <= din_s[i] | (latch_hi[i] & ~clr_latch);
          latch_lo[i] <= ~din_s[i] | (latch_lo[i] & ~clr_latch);
          if (zero)
            cnt[i] <= {15'h0000, ev};
          else if (ev && cnt[i] != `DWLC_CNT_MAX)
            cnt[i] <= cnt[i] + 16'h0001;
          else if (wrap)
            cnt[i] <= 16'h0000;
          if (wrap && !clr_cnt[i] && !rd_allc[i])
            ovf[i] <= 1'b1;
          else if (zero || rd_ovc[i])
            ovf[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// *** hw/dwlc_defs.vh ***
// address map, codes and timing constants of the digital i/o core
`ifndef DWLC_DEFS_VH
`define DWLC_DEFS_VH

// ----------------------------------------
// function codes
// ----------------------------------------
`define DWLC_FC_RD_COIL      8'h01
`define DWLC_FC_RD_DISC      8'h02
`define DWLC_FC_RD_HOLD      8'h03
`define DWLC_FC_RD_INREG     8'h04
`define DWLC_FC_WR_COIL      8'h05
`define DWLC_FC_WR_HOLD      8'h06
`define DWLC_FC_WR_COILS     8'h0F
`define DWLC_FC_WR_HOLDS     8'h10

// ----------------------------------------
// exception codes
// ----------------------------------------
`define DWLC_EXC_NONE        8'h00
`define DWLC_EXC_FUNC        8'h01
`define DWLC_EXC_ADDR        8'h02
`define DWLC_EXC_VALUE       8'h03
`define DWLC_EXC_HOST_TMO    8'h04

// ----------------------------------------
// coil values
// ----------------------------------------
`define DWLC_COIL_ON         16'hFF00
`define DWLC_COIL_OFF        16'h0000
`define DWLC_COIL_ONE        16'h0001

// ----------------------------------------
// element addresses (reference number minus one)
// ----------------------------------------
`define DWLC_A_OUT           16'd0
`define DWLC_A_IN            16'd32
`define DWLC_A_LATCH_HI      16'd64
`define DWLC_A_LATCH_LO      16'd96
`define DWLC_A_SAFE          16'd128
`define DWLC_A_PWR           16'd160
`define DWLC_A_WDT_EN        16'd260
`define DWLC_A_LATCH_CLR     16'd263
`define DWLC_A_WDT_FLAG      16'd269
`define DWLC_A_CNT_CLR       16'd512
`define DWLC_A_CNT_MODE      16'd544
`define DWLC_A_CNT16         16'd0
`define DWLC_A_CNT_VIEW      16'd32
`define DWLC_A_CNT_OVC       16'd96
`define DWLC_A_CNT_ALLC      16'd224
`define DWLC_A_TMO           16'd488
`define DWLC_A_KICK          16'd491
`define DWLC_A_BCAST         16'd12344
`define DWLC_BANK_LEN        16'd32
`define DWLC_VIEW_LEN        16'd64

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define DWLC_RST_TMO         8'h00
`define DWLC_RST_PWR         32'h0000_0000
`define DWLC_RST_SAFE        32'h0000_0000
`define DWLC_CLK_HZ          20000000
`define DWLC_TMO_UNIT_MS     100
`define DWLC_TMO_UNIT_CYC    (`DWLC_CLK_HZ / 1000 * `DWLC_TMO_UNIT_MS)
`define DWLC_CNT_MAX         16'hFFFF

`endif

// *** verif/dwlc_core_sva.sv ***
// port assertions of the digital i/o core
`timescale 1ns/1ns
`default_nettype none
`include "dwlc_defs.vh"
module dwlc_core_sva #(
  parameter [31:0] TENTH_CYCLES = 32'h001E_8480
) (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  // request and answer
  input wire logic        REQ_VALID,
  input wire logic [7:0]  REQ_FUNC,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [15:0] REQ_DATA,
  input wire logic        RSP_VALID,
  input wire logic [15:0] RSP_DATA,
  input wire logic [7:0]  RSP_EXC,
  // pins
  input wire logic [31:0] DIN,
  input wire logic [31:0] DOUT,
  input wire logic        HOST_TMO
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // ----------------------------------------
  // request shapes
  // ----------------------------------------
  sequence bcast_req;
    REQ_VALID && (REQ_FUNC == 8'h03 || REQ_FUNC == 8'h04) && REQ_ADDR == `DWLC_A_BCAST;
  endsequence
  sequence kick_req;
    REQ_VALID && REQ_FUNC == 8'h03 && REQ_ADDR == `DWLC_A_KICK;
  endsequence
  sequence flag_clr_req;
    REQ_VALID && REQ_FUNC == 8'h05 && REQ_ADDR == `DWLC_A_WDT_FLAG && (REQ_DATA == 16'hFF00 || REQ_DATA == 16'h0001);
  endsequence
  // flag must be settled: a clear taken one cycle earlier may still show on the port
  sequence out_wr_in_tmo;
    REQ_VALID && REQ_FUNC == 8'h05 && REQ_ADDR < 16'h0020 && (REQ_DATA == 16'hFF00 || REQ_DATA == 16'h0000)
      && HOST_TMO && $past(HOST_TMO) && !$past(REQ_VALID);
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  answer_cause_a: assert property (RSP_VALID |-> $past(REQ_VALID)) else $error("answer without a request");
  bcast_silent_a: assert property (bcast_req |=> !RSP_VALID) else $error("broadcast kick answered");
  kick_answer_a: assert property (kick_req |=> RSP_VALID && RSP_EXC == 8'h00 && RSP_DATA == 16'h0000)
    else $error("alive kick not answered normally");
  tmo_refuse_a: assert property (out_wr_in_tmo |=> RSP_VALID && RSP_EXC == 8'h04)
    else $error("output write during timeout not refused");
  flag_clear_a: assert property (flag_clr_req |=> ##[0:2] !HOST_TMO) else $error("timeout flag not cleared");
  tmo_range_a: assert property (REQ_VALID && REQ_FUNC == 8'h06 && REQ_ADDR == `DWLC_A_TMO && REQ_DATA[15:8] != 8'h00
    |=> RSP_VALID && RSP_EXC == 8'h03) else $error("timeout setting above 255 accepted");
  wo_read_a: assert property (REQ_VALID && REQ_FUNC == 8'h01 && (REQ_ADDR == `DWLC_A_LATCH_CLR
    || (REQ_ADDR >= 16'h0200 && REQ_ADDR < 16'h0220)) |=> RSP_VALID && RSP_EXC == 8'h02)
    else $error("write-only coil readable");
  coil_echo_a: assert property (REQ_VALID && REQ_FUNC == 8'h05 && REQ_ADDR == `DWLC_A_WDT_EN
    && (REQ_DATA == 16'hFF00 || REQ_DATA == 16'h0000) |=> RSP_VALID && RSP_EXC == 8'h00 && RSP_DATA == $past(REQ_DATA))
    else $error("enable coil write not echoed");
  safe_hold_a: assert property (HOST_TMO && $past(HOST_TMO) && $past(HOST_TMO, 2) && !$past(REQ_VALID)
    && !$past(REQ_VALID, 2) |-> $stable(DOUT)) else $error("outputs moved while in safe state");
endmodule
bind dwlc_core dwlc_core_sva #(.TENTH_CYCLES(TENTH_CYCLES)) u_sva (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .REQ_VALID(REQ_VALID), .REQ_FUNC(REQ_FUNC), .REQ_ADDR(REQ_ADDR), .REQ_DATA(REQ_DATA), .RSP_VALID(RSP_VALID),
  .RSP_DATA(RSP_DATA), .RSP_EXC(RSP_EXC), .DIN(DIN), .DOUT(DOUT), .HOST_TMO(HOST_TMO));
`default_nettype wire

// *** verif/dwlc_host_model.sv ***
// serial-link host model: one request, one answer
`timescale 1ns/1ns
`default_nettype none
module dwlc_host_model (
  // clock
  input  wire logic        CLK_SYS,
  // request lines
  output logic             REQ_VALID,
  output logic [7:0]       REQ_FUNC,
  output logic [15:0]      REQ_ADDR,
  output logic [15:0]      REQ_DATA,
  // answer lines
  input  wire logic        RSP_VALID,
  input  wire logic [15:0] RSP_DATA,
  input  wire logic [7:0]  RSP_EXC
);
  initial begin
    REQ_VALID = 1'b0;
    REQ_FUNC  = 8'h00;
    REQ_ADDR  = 16'h0000;
    REQ_DATA  = 16'h0000;
  end
  // caller passes element number minus one
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                      output logic v, output logic [15:0] rd, output logic [7:0] ex);
    @(posedge CLK_SYS);
    REQ_VALID <= 1'b1;
    REQ_FUNC  <= f;
    REQ_ADDR  <= a;
    REQ_DATA  <= d;
    @(posedge CLK_SYS);
    // released lines inverted so a stale request never looks fresh
    REQ_VALID <= 1'b0;
    REQ_FUNC  <= ~f;
    REQ_ADDR  <= ~a;
    REQ_DATA  <= ~d;
    #1;
    v  = RSP_VALID;
    rd = RSP_DATA;
    ex = RSP_EXC;
  endtask
endmodule
`default_nettype wire

// *** verif/dwlc_core_tb.sv ***
// self-checking testbench of the digital i/o core
`timescale 1ns/1ns
`default_nettype none
`include "dwlc_defs.vh"
module dwlc_core_tb;
  logic        clk_sys, rstn, req_valid, rsp_valid, host_tmo, v;
  logic [7:0]  req_func, rsp_exc, ex;
  logic [15:0] req_addr, req_data, rsp_data, rd;
  logic [31:0] din, dout, out_m, safe_m, pwr_m, hi_m, lo_m, r;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          ch, n;
  // short timer tick keeps the alive timeout at tens of cycles
  dwlc_core #(.TENTH_CYCLES(32'h0000_000A)) uut (.CLK_SYS(clk_sys), .RSTN(rstn), .REQ_VALID(req_valid),
    .REQ_FUNC(req_func), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .RSP_EXC(rsp_exc), .DIN(din), .DOUT(dout), .HOST_TMO(host_tmo));
  dwlc_host_model host (.CLK_SYS(clk_sys), .REQ_VALID(req_valid), .REQ_FUNC(req_func), .REQ_ADDR(req_addr),
    .REQ_DATA(req_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_EXC(rsp_exc));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                    input logic [15:0] e, input logic [7:0] x);
    host.xfer(f, a, d, v, rd, ex);
    chk({31'h0, v}, 32'h0000_0001);
    chk({24'h0, ex}, {24'h0, x});
    if (x == 8'h00) chk({16'h0, rd}, {16'h0, e});
  endtask
  function automatic logic [15:0] coil(input logic b);
    return b ? 16'hFF00 : 16'h0000;
  endfunction
  task automatic pulse(input int c, input int k);
    repeat (k) begin
      @(posedge clk_sys) din[c] <= 1'b1;
      @(posedge clk_sys) din[c] <= 1'b0;
    end
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    din = 32'h0000_0000;
    void'($urandom(53160));
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk(dout, 32'h0000_0000);
    chk({31'h0, host_tmo}, 32'h0000_0000);
    rq(8'h01, `DWLC_A_CNT_MODE, 16'h0000, 16'h0000, 8'h00);
    out_m = $urandom;
    safe_m = $urandom;
    pwr_m = $urandom;
    for (int i = 0; i < 32; i++) begin
      rq(8'h05, 16'(i), coil(out_m[i]), coil(out_m[i]), 8'h00);
      rq(8'h05, `DWLC_A_SAFE + 16'(i), coil(safe_m[i]), coil(safe_m[i]), 8'h00);
      rq(8'h05, `DWLC_A_PWR + 16'(i), coil(pwr_m[i]), coil(pwr_m[i]), 8'h00);
    end
    for (int i = 0; i < 32; i++) begin
      rq(8'h01, 16'(i), 16'h0000, {15'h0, out_m[i]}, 8'h00);
      rq(8'h01, `DWLC_A_SAFE + 16'(i), 16'h0000, {15'h0, safe_m[i]}, 8'h00);
      rq(8'h01, `DWLC_A_PWR + 16'(i), 16'h0000, {15'h0, pwr_m[i]}, 8'h00);
    end
    chk(dout, out_m);
    // low latches all set: inputs read low through reset
    hi_m = 32'h0000_0000;
    lo_m = 32'hFFFF_FFFF;
    r = $urandom;
    @(posedge clk_sys) din <= r;
    for (int k = 0; k < 2; k++) begin
      hi_m = hi_m | r;
      lo_m = lo_m | ~r;
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 32; i++) begin
        rq(8'h02, `DWLC_A_IN + 16'(i), 16'h0000, {15'h0, r[i]}, 8'h00);
        rq(8'h01, `DWLC_A_LATCH_HI + 16'(i), 16'h0000, {15'h0, hi_m[i]}, 8'h00);
        rq(8'h01, `DWLC_A_LATCH_LO + 16'(i), 16'h0000, {15'h0, lo_m[i]}, 8'h00);
      end
      rq(8'h05, `DWLC_A_LATCH_CLR, 16'h0001, 16'h0001, 8'h00);
      hi_m = 32'h0000_0000;
      lo_m = 32'h0000_0000;
    end
    rq(8'h01, `DWLC_A_LATCH_CLR, 16'h0000, 16'h0000, 8'h02);
    // counters on one random channel
    ch = $urandom % 32;
    n = 1 + $urandom % 20;
    @(posedge clk_sys) din <= 32'h0000_0000;
    repeat (3) @(posedge clk_sys);
    rq(8'h05, `DWLC_A_CNT_CLR + 16'(ch), 16'hFF00, 16'hFF00, 8'h00);
    rq(8'h01, `DWLC_A_CNT_CLR + 16'(ch), 16'h0000, 16'h0000, 8'h02);
    pulse(ch, n);
    rq(8'h04, 16'(ch), 16'h0000, 16'(n), 8'h00);
    rq(8'h04, `DWLC_A_CNT_VIEW + 16'(2 * ch), 16'h0000, 16'(n), 8'h00);
    rq(8'h04, `DWLC_A_CNT_VIEW + 16'(2 * ch + 1), 16'h0000, 16'h0000, 8'h00);
    rq(8'h04, `DWLC_A_CNT_OVC + 16'(2 * ch), 16'h0000, 16'(n), 8'h00);
    rq(8'h04, `DWLC_A_CNT_ALLC + 16'(2 * ch), 16'h0000, 16'(n), 8'h00);
    rq(8'h04, 16'(ch), 16'h0000, 16'h0000, 8'h00);
    pulse(ch, 3);
    rq(8'h0F, `DWLC_A_CNT_CLR + 16'(ch), 16'h0000, 16'h0000, 8'h00);
    rq(8'h04, 16'(ch), 16'h0000, 16'h0003, 8'h00);
    rq(8'h0F, `DWLC_A_CNT_CLR + 16'(ch), 16'h0001, 16'h0001, 8'h00);
    rq(8'h04, 16'(ch), 16'h0000, 16'h0000, 8'h00);
    rq(8'h05, `DWLC_A_CNT_MODE, 16'hFF00, 16'hFF00, 8'h00);
    rq(8'h01, `DWLC_A_CNT_MODE, 16'h0000, 16'h0001, 8'h00);
    // alive timer: setting 2 tenths is 20 cycles here
    rq(8'h01, `DWLC_A_WDT_EN, 16'h0000, 16'h0000, 8'h00);
    rq(8'h06, `DWLC_A_TMO, 16'h0100, 16'h0000, 8'h03);
    rq(8'h06, `DWLC_A_TMO, 16'h0002, 16'h0002, 8'h00);
    rq(8'h03, `DWLC_A_TMO, 16'h0000, 16'h0002, 8'h00);
    rq(8'h05, `DWLC_A_WDT_EN, 16'hFF00, 16'hFF00, 8'h00);
    rq(8'h01, `DWLC_A_WDT_EN, 16'h0000, 16'h0001, 8'h00);
    repeat (10) @(posedge clk_sys);
    rq(8'h03, `DWLC_A_KICK, 16'h0000, 16'h0000, 8'h00);
    repeat (12) @(posedge clk_sys);
    host.xfer(8'h04, `DWLC_A_BCAST, 16'h0000, v, rd, ex);
    chk({31'h0, v}, 32'h0000_0000);
    repeat (12) @(posedge clk_sys);
    #1 chk({31'h0, host_tmo}, 32'h0000_0000);
    repeat (30) @(posedge clk_sys);
    #1 chk({31'h0, host_tmo}, 32'h0000_0001);
    chk(dout, safe_m);
    rq(8'h01, `DWLC_A_WDT_FLAG, 16'h0000, 16'h0001, 8'h00);
    rq(8'h05, `DWLC_A_OUT, 16'hFF00, 16'h0000, 8'h04);
    rq(8'h05, `DWLC_A_WDT_EN, 16'h0000, 16'h0000, 8'h00);
    rq(8'h05, `DWLC_A_WDT_FLAG, 16'h0001, 16'h0001, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 chk({31'h0, host_tmo}, 32'h0000_0000);
    chk(dout, out_m);
    give_verdict();
  end
endmodule
`default_nettype wire
